// ---- logic/omsc_cfg.svh ----
// constants of the operating-mode and system-control block
`ifndef OMSC_CFG_SVH
`define OMSC_CFG_SVH
`define OMSC_ADDR_W 20
`define OMSC_OFS_MODE_IND 20'hee011
`define OMSC_OFS_SYS_CTRL 20'hee012
`define OMSC_SYS_CTRL_RST 8'h09
`define OMSC_MODE_IND_TOP 8'hc0
`define OMSC_BIT_SSB 7
`define OMSC_BIT_STS_HI 6
`define OMSC_BIT_STS_LO 4
`define OMSC_BIT_UBE 3
`define OMSC_BIT_EDGE 2
`define OMSC_BIT_SOE 1
`define OMSC_BIT_RAM 0
`define OMSC_WAIT_0 19'h02000
`define OMSC_WAIT_1 19'h04000
`define OMSC_WAIT_2 19'h08000
`define OMSC_WAIT_3 19'h10000
`define OMSC_WAIT_4 19'h20000
`define OMSC_WAIT_5 19'h40000
`define OMSC_WAIT_6 19'h00400
`define OMSC_WAIT_W 19
`endif

// ---- logic/omsc_pkg.sv ----
// types of the operating-mode and system-control block
package omsc_pkg;
  typedef enum logic [7:0] {
    OMSC_MODE_NONE = 8'h00,
    OMSC_MODE_1 = 8'h01,
    OMSC_MODE_2 = 8'h02,
    OMSC_MODE_3 = 8'h04,
    OMSC_MODE_4 = 8'h08,
    OMSC_MODE_5 = 8'h10,
    OMSC_MODE_6 = 8'h20,
    OMSC_MODE_7 = 8'h40
  } omsc_mode_t;
  typedef enum logic [1:0] {
    OMSC_SPACE_64K = 2'h0,
    OMSC_SPACE_1M = 2'h1,
    OMSC_SPACE_16M = 2'h2
  } omsc_space_t;
  typedef enum logic [1:0] {
    OMSC_BUS_NONE = 2'h0,
    OMSC_BUS_8 = 2'h1,
    OMSC_BUS_16 = 2'h2
  } omsc_bus_t;
endpackage

// ---- logic/omsc_mode_dec.sv ----
// decoder from mode-pin code to mode and its static properties
`timescale 1ns/100ps
module omsc_mode_dec (
  input wire logic [2:0] code,
  output omsc_pkg::omsc_mode_t mode,
  output omsc_pkg::omsc_space_t space,
  output omsc_pkg::omsc_bus_t init_bus,
  output logic expanded,
  output logic rom_on,
  output logic legal
);
  always_comb
  begin
    mode = omsc_pkg::OMSC_MODE_NONE;
    space = omsc_pkg::OMSC_SPACE_64K;
    init_bus = omsc_pkg::OMSC_BUS_NONE;
    expanded = 1'b0;
    rom_on = 1'b0;
    legal = 1'b1;
    case (code)
      3'h1:
      begin
        mode = omsc_pkg::OMSC_MODE_1;
        space = omsc_pkg::OMSC_SPACE_1M;
        init_bus = omsc_pkg::OMSC_BUS_8;
        expanded = 1'b1;
      end
      3'h2:
      begin
        mode = omsc_pkg::OMSC_MODE_2;
        space = omsc_pkg::OMSC_SPACE_1M;
        init_bus = omsc_pkg::OMSC_BUS_16;
        expanded = 1'b1;
      end
      3'h3:
      begin
        mode = omsc_pkg::OMSC_MODE_3;
        space = omsc_pkg::OMSC_SPACE_16M;
        init_bus = omsc_pkg::OMSC_BUS_8;
        expanded = 1'b1;
      end
      3'h4:
      begin
        mode = omsc_pkg::OMSC_MODE_4;
        space = omsc_pkg::OMSC_SPACE_16M;
        init_bus = omsc_pkg::OMSC_BUS_16;
        expanded = 1'b1;
      end
      3'h5:
      begin
        mode = omsc_pkg::OMSC_MODE_5;
        space = omsc_pkg::OMSC_SPACE_16M;
        init_bus = omsc_pkg::OMSC_BUS_8;
        expanded = 1'b1;
        rom_on = 1'b1;
      end
      3'h6:
      begin
        mode = omsc_pkg::OMSC_MODE_6;
        space = omsc_pkg::OMSC_SPACE_64K;
        rom_on = 1'b1;
      end
      3'h7:
      begin
        mode = omsc_pkg::OMSC_MODE_7;
        space = omsc_pkg::OMSC_SPACE_1M;
        rom_on = 1'b1;
      end
      default:
      begin
        legal = 1'b0;
      end
    endcase
  end
endmodule

// ---- logic/omsc_wait_cnt.sv ----
// settling-wait counter for the exit from software standby
`timescale 1ns/100ps
`include "omsc_cfg.svh"
module omsc_wait_cnt (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic [2:0] sel,
  output logic busy,
  output logic done,
  output logic illegal
);
  logic [`OMSC_WAIT_W-1:0] count;
  logic [`OMSC_WAIT_W-1:0] load;
  assign load = (sel == 3'h0) ? `OMSC_WAIT_0 :
                (sel == 3'h1) ? `OMSC_WAIT_1 :
                (sel == 3'h2) ? `OMSC_WAIT_2 :
                (sel == 3'h3) ? `OMSC_WAIT_3 :
                (sel == 3'h4) ? `OMSC_WAIT_4 :
                (sel == 3'h5) ? `OMSC_WAIT_5 :
                (sel == 3'h6) ? `OMSC_WAIT_6 : `OMSC_WAIT_0;
  assign illegal = (sel == 3'h7);
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      count <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start && !busy && !illegal)
      begin
        count <= load - `OMSC_WAIT_W'(1);
        busy <= 1'b1;
      end
      else if (busy)
      begin
        if (count == '0)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        else
        begin
          count <= count - `OMSC_WAIT_W'(1);
        end
      end
    end
  end
endmodule

// ---- logic/omsc_top.sv ----
// operating-mode decode, mode indicator and system-control register
//
// Chosen here: strobed register access.
`timescale 1ns/100ps
`include "omsc_cfg.svh"
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - mode pins 001..111 select modes 1..7; 000 is prohibited.
// - mode fixes space and initial bus: 1,3,5 8-bit; 2,4 16-bit; 6,7 none.
// - modes 1-4 allow external access and disable on-chip ROM.
// - modes 1,2 address 1 Mbyte; modes 3,4 address 16 Mbytes.
// - mode 5 enables external and on-chip ROM, 16 Mbytes.
// - modes 6,7 single-chip; mode 6 64 kbytes, mode 7 1 Mbyte.
// - RAM enabled in modes 1-5 unless ram enable cleared, then external.
// - expanded bus is 8-bit only when every area is set 8-bit.
// - mode indicator read-only; bits 7,6 read 1, bits 5..3 read 0.
// - mode indicator bits 2..0 give mode pins sampled at the read.
// - in flash boot mode the top status bit is mode pin 2 inverted.
// - system control 8-bit read/write, reset 0x09, fields as laid out.
// - timer select sets standby settling wait; code 111 illegal.
// - edge select 0 picks falling, 1 rising interrupt edge.
// - user bit enable 0 makes flag a mask bit, 1 a user bit.
// - standby floats bus when output enable 0, else holds and drives high.
module omsc_top (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic mode_pin_2,
  input wire logic mode_pin_1,
  input wire logic mode_pin_0,
  input wire logic flash_boot,
  input wire logic [`OMSC_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] area_bus_width_register,
  input wire logic standby_req,
  input wire logic standby_wake,
  input wire logic nmi_in,
  output logic [7:0] mode_onehot,
  output logic [1:0] space_size,
  output logic [1:0] bus_width,
  output logic mode_illegal,
  output logic ext_access_en,
  output logic rom_en,
  output logic ram_internal,
  output logic standby_enable,
  output logic [2:0] standby_timer_select,
  output logic user_bit_enable,
  output logic interrupt_edge_select,
  output logic standby_output_enable,
  output logic ram_enable,
  output logic in_standby,
  output logic settle_busy,
  output logic settle_illegal,
  output logic nmi_event,
  output logic flag_is_mask,
  output logic bus_float,
  output logic bus_hold,
  output logic ctrl_drive_high
);
  //////////////////////////////////////////////////////////////////////////
  // mode decode
  logic [2:0] pin_code;
  omsc_pkg::omsc_mode_t dec_mode;
  omsc_pkg::omsc_space_t dec_space;
  omsc_pkg::omsc_bus_t dec_bus;
  logic dec_exp;
  logic dec_rom;
  logic dec_legal;
  assign pin_code = {mode_pin_2, mode_pin_1, mode_pin_0};
  // pins assumed static outside reset, so no resync of the decode
  omsc_mode_dec u_dec (
    .code(pin_code),
    .mode(dec_mode),
    .space(dec_space),
    .init_bus(dec_bus),
    .expanded(dec_exp),
    .rom_on(dec_rom),
    .legal(dec_legal)
  );
  //////////////////////////////////////////////////////////////////////////
  // register file
  logic [7:0] sys_ctrl;
  logic sel_ind;
  logic sel_ctrl;
  logic [7:0] ind_value;
  logic [7:0] next_rdata;
  assign sel_ind = (reg_addr == `OMSC_OFS_MODE_IND);
  assign sel_ctrl = (reg_addr == `OMSC_OFS_SYS_CTRL);
  // pins are sampled at the read itself, not held in a latch
  assign ind_value = `OMSC_MODE_IND_TOP |
                     {5'h00, flash_boot ? ~mode_pin_2 : mode_pin_2, mode_pin_1, mode_pin_0};
  assign next_rdata = !reg_rd ? 8'h00 :
                      sel_ind ? ind_value :
                      sel_ctrl ? sys_ctrl : 8'h00;
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      sys_ctrl <= `OMSC_SYS_CTRL_RST;
    else if (reg_wr && sel_ctrl)
      sys_ctrl <= reg_wdata;
  end
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= next_rdata;
  end
  //////////////////////////////////////////////////////////////////////////
  // bus width and memory map
  logic all_areas_8;
  logic [1:0] next_bus;
  logic next_ram_int;
  assign all_areas_8 = (area_bus_width_register == 8'hff);
  // expanded modes follow the area widths; reset value of that register
  // is supplied by the bus controller to match the initial bus mode
  assign next_bus = !dec_exp ? omsc_pkg::OMSC_BUS_NONE :
                    all_areas_8 ? omsc_pkg::OMSC_BUS_8 : omsc_pkg::OMSC_BUS_16;
  assign next_ram_int = dec_legal && (!dec_exp || sys_ctrl[`OMSC_BIT_RAM]);
  //////////////////////////////////////////////////////////////////////////
  // standby and settling wait
  logic wait_busy;
  logic wait_done;
  logic wait_illegal;
  logic wait_start;
  assign wait_start = in_standby && standby_wake;
  omsc_wait_cnt u_wait (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .start(wait_start),
    .sel(sys_ctrl[`OMSC_BIT_STS_HI:`OMSC_BIT_STS_LO]),
    .busy(wait_busy),
    .done(wait_done),
    .illegal(wait_illegal)
  );
  logic next_standby;
  assign next_standby = wait_done ? 1'b0 :
                        (standby_req && sys_ctrl[`OMSC_BIT_SSB]) ? 1'b1 : in_standby;
  //////////////////////////////////////////////////////////////////////////
  // interrupt edge detect
  logic nmi_prev;
  logic next_nmi;
  assign next_nmi = sys_ctrl[`OMSC_BIT_EDGE] ? (nmi_in && !nmi_prev) :
                    (!nmi_in && nmi_prev);
  //////////////////////////////////////////////////////////////////////////
  // registered outputs
  logic soe;
  assign soe = sys_ctrl[`OMSC_BIT_SOE];
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mode_onehot <= 8'h00;
      space_size <= 2'h0;
      bus_width <= 2'h0;
      mode_illegal <= 1'b0;
      ext_access_en <= 1'b0;
      rom_en <= 1'b0;
      ram_internal <= 1'b0;
      in_standby <= 1'b0;
      settle_busy <= 1'b0;
      settle_illegal <= 1'b0;
      nmi_prev <= 1'b0;
      nmi_event <= 1'b0;
      bus_float <= 1'b0;
      bus_hold <= 1'b0;
      ctrl_drive_high <= 1'b0;
    end
    else
    begin
      mode_onehot <= dec_mode;
      space_size <= dec_space;
      bus_width <= next_bus;
      mode_illegal <= !dec_legal;
      ext_access_en <= dec_exp;
      rom_en <= dec_rom;
      ram_internal <= next_ram_int;
      in_standby <= next_standby;
      settle_busy <= wait_busy;
      settle_illegal <= wait_illegal;
      nmi_prev <= nmi_in;
      nmi_event <= next_nmi;
      bus_float <= next_standby && !soe;
      bus_hold <= next_standby && soe;
      ctrl_drive_high <= next_standby && soe;
    end
  end
  // field outputs mirror the register bits; flag_is_mask is the user bit enable inverted
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      standby_enable <= 1'b0;
      standby_timer_select <= 3'h0;
      user_bit_enable <= 1'b1;
      interrupt_edge_select <= 1'b0;
      standby_output_enable <= 1'b0;
      ram_enable <= 1'b1;
      flag_is_mask <= 1'b0;
    end
    else
    begin
      standby_enable <= sys_ctrl[`OMSC_BIT_SSB];
      standby_timer_select <= sys_ctrl[`OMSC_BIT_STS_HI:`OMSC_BIT_STS_LO];
      user_bit_enable <= sys_ctrl[`OMSC_BIT_UBE];
      interrupt_edge_select <= sys_ctrl[`OMSC_BIT_EDGE];
      standby_output_enable <= soe;
      ram_enable <= sys_ctrl[`OMSC_BIT_RAM];
      flag_is_mask <= !sys_ctrl[`OMSC_BIT_UBE];
    end
  end
endmodule

// ---- tb/omsc_top_props.sv ----
// checker of the operating-mode block port behaviour
`timescale 1ns/100ps
`include "omsc_cfg.svh"
module omsc_top_props (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic mode_pin_2,
  input wire logic mode_pin_1,
  input wire logic mode_pin_0,
  input wire logic flash_boot,
  input wire logic [`OMSC_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] area_bus_width_register,
  input wire logic [7:0] mode_onehot,
  input wire logic [1:0] space_size,
  input wire logic [1:0] bus_width,
  input wire logic mode_illegal,
  input wire logic ext_access_en,
  input wire logic rom_en,
  input wire logic ram_internal,
  input wire logic standby_enable,
  input wire logic [2:0] standby_timer_select,
  input wire logic user_bit_enable,
  input wire logic interrupt_edge_select,
  input wire logic standby_output_enable,
  input wire logic ram_enable,
  input wire logic flag_is_mask
);
  wire logic [2:0] code = {mode_pin_2, mode_pin_1, mode_pin_0};
  wire logic mapped = reg_addr == `OMSC_OFS_MODE_IND || reg_addr == `OMSC_OFS_SYS_CTRL;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  //////////////////////////////////////////////////////////////////////////////
  // decode outputs are registered, so the first edge after release is skipped
  a_mode_decode: assert property (
    !$past(sys_rst) |-> mode_illegal == (code == 3'h0)
      && mode_onehot == ((code == 3'h0) ? 8'h00 : 8'h01 << (code - 3'h1)))
    else $error("mode decode mismatch");
  a_space_map: assert property (
    !$past(sys_rst) && code != 3'h0 |-> space_size == ((code == 3'h6) ? 2'h0
      : (code inside {3'h3, 3'h4, 3'h5}) ? 2'h2 : 2'h1))
    else $error("address space mismatch");
  a_bus_width: assert property (
    !$past(sys_rst) && code != 3'h0 && $stable(area_bus_width_register) |-> bus_width ==
      ((code >= 3'h6) ? 2'h0 : (area_bus_width_register == 8'hff) ? 2'h1 : 2'h2))
    else $error("bus width mismatch");
  a_rom_ext: assert property (
    !$past(sys_rst) && code != 3'h0 |-> rom_en == (code >= 3'h5)
      && ext_access_en == (code <= 3'h5))
    else $error("rom or external access mismatch");
  a_ram_map: assert property (
    !$past(sys_rst) && code != 3'h0 && $stable(ram_enable)
      |-> ram_internal == (code >= 3'h6 || ram_enable))
    else $error("ram mapping mismatch");
  a_ind_read: assert property (
    $past(reg_rd) && $past(reg_addr) == `OMSC_OFS_MODE_IND |-> reg_rdata == {2'h3, 3'h0,
      $past(mode_pin_2) ^ $past(flash_boot), $past(mode_pin_1), $past(mode_pin_0)})
    else $error("mode indicator read mismatch");
  a_rdata_idle: assert property (
    !$past(reg_rd) || !$past(mapped) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  a_field_write: assert property (
    reg_wr && reg_addr == `OMSC_OFS_SYS_CTRL |-> ##2 {standby_enable, standby_timer_select,
      user_bit_enable, interrupt_edge_select, standby_output_enable, ram_enable}
      == $past(reg_wdata, 2))
    else $error("control fields mismatch");
  a_mask_flag: assert property (
    $stable(user_bit_enable) |-> flag_is_mask == !user_bit_enable)
    else $error("mask flag mismatch");
endmodule

// ---- tb/omsc_strap.sv ----
// board strapping model that sets the mode pins
`timescale 1ns/100ps
module omsc_strap (
  input wire logic sys_rst,
  input wire logic [2:0] code,
  output logic mode_pin_2,
  output logic mode_pin_1,
  output logic mode_pin_0
);
  // straps are static: a new code only lands while reset is held
  always_latch
    if (sys_rst)
      {mode_pin_2, mode_pin_1, mode_pin_0} <= code;
endmodule

// ---- tb/test_operating_mode_system_control.sv ----
// testbench of the operating-mode and system-control block
`timescale 1ns/100ps
`include "omsc_cfg.svh"
module test_operating_mode_system_control;
  logic ref_clk, sys_rst, flash_boot, reg_wr, reg_rd, standby_req, standby_wake, nmi_in;
  logic [2:0] code, standby_timer_select;
  logic [`OMSC_ADDR_W-1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, area_bus_width_register, mode_onehot;
  logic [1:0] space_size, bus_width;
  logic mode_pin_2, mode_pin_1, mode_pin_0, mode_illegal, ext_access_en, rom_en, ram_internal;
  logic standby_enable, user_bit_enable, interrupt_edge_select, standby_output_enable;
  logic ram_enable, in_standby, settle_busy, settle_illegal, nmi_event, flag_is_mask;
  logic bus_float, bus_hold, ctrl_drive_high;
  int err_total, samples_checked;
  localparam logic [19:0] IND = `OMSC_OFS_MODE_IND;
  localparam logic [19:0] SYS = `OMSC_OFS_SYS_CTRL;
  omsc_strap u_strap (.sys_rst(sys_rst), .code(code), .mode_pin_2(mode_pin_2),
    .mode_pin_1(mode_pin_1), .mode_pin_0(mode_pin_0));
  omsc_top u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .mode_pin_2(mode_pin_2),
    .mode_pin_1(mode_pin_1), .mode_pin_0(mode_pin_0), .flash_boot(flash_boot),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .area_bus_width_register(area_bus_width_register),
    .standby_req(standby_req), .standby_wake(standby_wake), .nmi_in(nmi_in),
    .mode_onehot(mode_onehot), .space_size(space_size), .bus_width(bus_width),
    .mode_illegal(mode_illegal), .ext_access_en(ext_access_en), .rom_en(rom_en),
    .ram_internal(ram_internal), .standby_enable(standby_enable),
    .standby_timer_select(standby_timer_select), .user_bit_enable(user_bit_enable),
    .interrupt_edge_select(interrupt_edge_select),
    .standby_output_enable(standby_output_enable), .ram_enable(ram_enable),
    .in_standby(in_standby), .settle_busy(settle_busy), .settle_illegal(settle_illegal),
    .nmi_event(nmi_event), .flag_is_mask(flag_is_mask), .bus_float(bus_float),
    .bus_hold(bus_hold), .ctrl_drive_high(ctrl_drive_high));
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rst(input logic [2:0] c);
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    code <= c;
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [19:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  task automatic complete_run;
    $display("checks=%0d errors=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_modes;
    for (int c = 0; c < 8; c++)
    begin
      area_bus_width_register <= (c == 2 || c == 4) ? 8'h00 : 8'hff;
      rst(c[2:0]);
      chk(mode_onehot, (c == 0) ? 8'h00 : 8'h01 << (c - 1));
      chk({7'h0, mode_illegal}, {7'h0, c == 0});
      if (c != 0)
      begin
        chk({6'h0, space_size}, (c == 6) ? 8'h00 : (c >= 3 && c <= 5) ? 8'h02 : 8'h01);
        chk({6'h0, bus_width}, (c >= 6) ? 8'h00 : (c == 2 || c == 4) ? 8'h02 : 8'h01);
        chk({6'h0, rom_en, ext_access_en}, {6'h0, c >= 5, c <= 5});
      end
      for (int f = 0; f < 2; f++)
      begin
        flash_boot <= f[0];
        rd(IND, {2'h3, 3'h0, c[2] ^ f[0], c[1:0]});
      end
      wr(IND, 8'h3f);
      rd(IND, {2'h3, 3'h0, c[2] ^ 1'b1, c[1:0]});
    end
  endtask
  task automatic t_ctrl;
    rst(3'h1);
    rd(SYS, 8'h09);
    chk({6'h0, flag_is_mask, ram_internal}, 8'h01);
    // one 16-bit area is enough to leave the narrow bus
    area_bus_width_register <= 8'hfe;
    repeat (3) @(posedge ref_clk);
    #1;
    chk({6'h0, bus_width}, 8'h02);
    wr(SYS, 8'h00);
    rd(SYS, 8'h00);
    chk({6'h0, flag_is_mask, ram_internal}, 8'h02);
    wr(SYS, 8'hf6);
    rd(SYS, 8'hf6);
    chk({standby_enable, standby_timer_select, user_bit_enable, interrupt_edge_select,
      standby_output_enable, ram_enable}, 8'hf6);
    chk({7'h0, settle_illegal}, 8'h01);
    wr(20'hee013, 8'h55);
    rd(20'hee013, 8'h00);
    rd(SYS, 8'hf6);
  endtask
  task automatic t_nmi(input logic s);
    int n;
    wr(SYS, {4'h0, 1'b1, s, 2'h3});
    nmi_in <= !s;
    repeat (4) @(posedge ref_clk);
    for (int k = 0; k < 2; k++)
    begin
      n = 0;
      nmi_in <= s ^ k[0];
      repeat (4)
      begin
        @(posedge ref_clk);
        #1;
        n += (nmi_event === 1'b1);
      end
      chk(n[7:0], (k == 0) ? 8'h01 : 8'h00);
    end
  endtask
  task automatic t_stby(input logic oe);
    int n;
    wr(SYS, {5'h1d, 1'b0, oe, 1'b1});
    @(posedge ref_clk);
    standby_req <= 1'b1;
    @(posedge ref_clk);
    standby_req <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk({4'h0, in_standby, bus_float, bus_hold, ctrl_drive_high}, oe ? 8'h0b : 8'h0c);
    @(posedge ref_clk);
    standby_wake <= 1'b1;
    @(posedge ref_clk);
    standby_wake <= 1'b0;
    // busy shows one edge after the counter loads
    repeat (2) @(posedge ref_clk);
    #1;
    chk({7'h0, settle_busy}, 8'h01);
    n = 2;
    while (in_standby === 1'b1 && n < 2000)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk({7'h0, n >= 1020 && n <= 1030}, 8'h01);
    chk({7'h0, settle_busy}, 8'h00);
    chk({5'h0, bus_float, bus_hold, ctrl_drive_high}, 8'h00);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {sys_rst, code, flash_boot, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 3'h1, 31'h0};
    {area_bus_width_register, standby_req, standby_wake, nmi_in} = 11'h7f8;
    t_modes;
    t_ctrl;
    t_nmi(1'b0);
    t_nmi(1'b1);
    t_stby(1'b1);
    t_stby(1'b0);
    complete_run;
  end
  // the slowest path is two standby exits of about a thousand cycles each
  initial
  begin
    #500000;
    err_total++;
    complete_run;
  end
endmodule
bind omsc_top omsc_top_props u_props (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .mode_pin_2(mode_pin_2), .mode_pin_1(mode_pin_1), .mode_pin_0(mode_pin_0),
  .flash_boot(flash_boot), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .area_bus_width_register(area_bus_width_register),
  .mode_onehot(mode_onehot), .space_size(space_size), .bus_width(bus_width),
  .mode_illegal(mode_illegal), .ext_access_en(ext_access_en), .rom_en(rom_en),
  .ram_internal(ram_internal), .standby_enable(standby_enable),
  .standby_timer_select(standby_timer_select), .user_bit_enable(user_bit_enable),
  .interrupt_edge_select(interrupt_edge_select),
  .standby_output_enable(standby_output_enable), .ram_enable(ram_enable),
  .flag_is_mask(flag_is_mask));
